// *** hw/ssi_top.sv ***
// Switch status indicator: LEDs, fault contact and configuration plug control
//
// How it works
// - Mode A: no link keeps port dark
// - Mode A: link and forwarding, steady green
// - Mode A: blocking port blinks green once/second
// - Mode A: disabled port blinks green thrice/second
// - Mode A: mirror destination blinks four/second
// - Mode A: receive activity shows yellow
// - Mode B: speed as dark, green, orange
// - Mode B: fixed speed shows configured speed
// - Mode B: autonegotiation and problem, dark
// - Mode C: half dark, full green
// - Mode D: dark port unmonitored, no fault
// - Mode D: green monitored, lost link faults
// - Modes A-C: supply green while good
// - Combined supply: dark, orange, green by count
// - Mode D: green supply monitored, loss faults
// - Mode D: dark supply unmonitored, no fault
// - Empty plug at startup gets whole configuration
// - Accepted plug receives runtime changes automatically
// - Plug inserted: internal memory untouched
// - Accepted written plug loaded at startup
// - Only compatible plug contents accepted
// - Plug problems flagged in status and fault
// - One idle minute returns to mode A
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
module ssi_top
  import ssi_pkg::*;
#(
  parameter int NPORT = 8,
  parameter int BLINK_DIV = BLINK_DIV_CYCLES,
  parameter logic [15:0] TIMEOUT_TICKS = 16'(MODE_TIMEOUT_TICKS)
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Front panel pins
  input wire logic mode_button,
  input wire logic [1:0] supply_good,
  // Port state from the switch core
  input wire ssi_port_stat_t [NPORT-1:0] port_stat,
  // Configuration plug
  input wire logic plug_present,
  input wire logic plug_blank,
  input wire logic plug_compat,
  input wire logic plug_xfer_done,
  input wire logic plug_xfer_err,
  output logic plug_store_req,
  output logic plug_load_req,
  output logic int_mem_allow,
  output logic plug_diag,
  // Indicators and signaling contact
  output ssi_color_t [NPORT-1:0] port_indicator,
  output logic supply_one_indicator,
  output logic supply_two_indicator,
  output ssi_color_t supply_indicator,
  output ssi_color_t view_select_indicator,
  output logic fault_contact
);

  typedef struct packed {
    logic btn_s1;
    logic btn_s2;
    logic btn_prev;
    logic [1:0] sup_s1;
    logic [1:0] sup_s2;
    logic plg_s1;
    logic plg_s2;
    ssi_mode_t mode;
    logic [15:0] to_cnt;
    ssi_plug_t pstate;
    logic [2:0] settle;
    logic store_pend;
    logic [2:0] err;
    logic [NPORT-1:0] port_mon;
    logic [1:0] sup_mon;
    logic fault;
    logic sup1;
    logic sup2;
    ssi_color_t supc;
    ssi_color_t viewc;
    logic [31:0] rdata;
    logic slverr;
  } ssi_top_state_t;

  ssi_top_state_t s;
  ssi_top_state_t next_s;

  logic tick;
  ssi_blink_t blink;
  logic [NPORT-1:0] link_vec;
  logic btn_edge;
  logic apb_setup;
  logic apb_write;
  logic addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Shared blink rates
  ssi_blink #(
    .DIV(BLINK_DIV)
  ) u_blink (
    .clk,
    .rst_b,
    .tick,
    .blink
  );

  // One indicator per port
  for (genvar i = 0; i < NPORT; i++)
  begin : g_port
    ssi_port_led u_led (
      .clk,
      .rst_b,
      .mode(s.mode),
      .blink,
      .monitored(s.port_mon[i]),
      .stat(port_stat[i]),
      .color(port_indicator[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  always_comb
  begin
    for (int i = 0; i < NPORT; i++)
      link_vec[i] = port_stat[i].link;
  end

  assign btn_edge = s.btn_s2 & ~s.btn_prev;
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pwrite;
  assign addr_ok = (paddr == REG_STATUS) || (paddr == REG_PORT_MON) ||
                   (paddr == REG_SUP_MON) || (paddr == REG_PLUG_CTRL) ||
                   (paddr == REG_PLUG_ERR);

  // Combined supply colour from a two-bit set
  function automatic ssi_color_t ssi_pair_col(input logic [1:0] v);
    case (v)
      2'h0: return COL_OFF;
      2'h3: return COL_GREEN;
      default: return COL_ORANGE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    next_s = s;

    // Pin synchronisers; first stage feeds only the second
    next_s.btn_s1 = mode_button;
    next_s.btn_s2 = s.btn_s1;
    next_s.btn_prev = s.btn_s2;
    next_s.sup_s1 = supply_good;
    next_s.sup_s2 = s.sup_s1;
    next_s.plg_s1 = plug_present;
    next_s.plg_s2 = s.plg_s1;

    // Button steps A-B-C-D; no debounce, the pin is assumed clean
    if (btn_edge)
    begin
      next_s.to_cnt = '0;
      case (s.mode)
        MODE_A: next_s.mode = MODE_B;
        MODE_B: next_s.mode = MODE_C;
        MODE_C: next_s.mode = MODE_D;
        default: next_s.mode = MODE_A;
      endcase
    end
    else if (tick && s.mode != MODE_A)
    begin
      if (s.to_cnt >= TIMEOUT_TICKS - 16'h0001)
      begin
        next_s.mode = MODE_A;
        next_s.to_cnt = '0;
      end
      else
        next_s.to_cnt = s.to_cnt + 16'h0001;
    end

    // Plug sequencing; removal is only legal powered off, so faults stick
    case (s.pstate)
      PL_START:
      begin
        if (s.settle == 3'(PLUG_SETTLE_CYCLES - 1))
        begin
          if (!s.plg_s2)
            next_s.pstate = PL_NONE;
          else if (plug_blank)
            next_s.pstate = PL_STORE;
          else if (plug_compat)
            next_s.pstate = PL_LOAD;
          else
          begin
            next_s.pstate = PL_REFUSE;
            next_s.err[ERR_INCOMPAT_BIT] = 1'b1;
          end
        end
        else
          next_s.settle = s.settle + 3'h1;
      end
      PL_NONE:
        next_s.pstate = PL_NONE;
      PL_STORE, PL_LOAD:
      begin
        if (!s.plg_s2)
        begin
          next_s.pstate = PL_FAULT;
          next_s.err[ERR_REMOVED_BIT] = 1'b1;
        end
        else if (plug_xfer_err)
        begin
          next_s.pstate = PL_FAULT;
          next_s.err[ERR_MALF_BIT] = 1'b1;
        end
        else if (plug_xfer_done)
          next_s.pstate = PL_ACCEPT;
      end
      PL_ACCEPT:
      begin
        if (!s.plg_s2)
        begin
          next_s.pstate = PL_FAULT;
          next_s.err[ERR_REMOVED_BIT] = 1'b1;
        end
        else if (plug_xfer_err)
        begin
          next_s.pstate = PL_FAULT;
          next_s.err[ERR_MALF_BIT] = 1'b1;
        end
        else if (s.store_pend)
        begin
          next_s.pstate = PL_STORE;
          next_s.store_pend = 1'b0;
        end
      end
      PL_REFUSE:
      begin
        if (!s.plg_s2)
        begin
          next_s.pstate = PL_FAULT;
          next_s.err[ERR_REMOVED_BIT] = 1'b1;
        end
      end
      PL_FAULT:
        next_s.pstate = PL_FAULT;
      default:
        next_s.pstate = PL_START;
    endcase

    // Register writes; hardware sets above win over clears here
    if (apb_write)
    begin
      case (paddr)
        REG_PORT_MON: next_s.port_mon = pwdata[NPORT-1:0];
        REG_SUP_MON: next_s.sup_mon = pwdata[1:0];
        REG_PLUG_CTRL:
        begin
          if (pwdata[CTRL_CHANGED_BIT])
            next_s.store_pend = 1'b1;
        end
        REG_PLUG_ERR: next_s.err = next_s.err & ~(pwdata[2:0] & ~(next_s.err ^ s.err));
        default: ;
      endcase
    end

    // Read data and error captured in the setup cycle
    if (apb_setup)
    begin
      next_s.rdata = '0;
      next_s.slverr = ~addr_ok;
      case (paddr)
        REG_STATUS:
        begin
          next_s.rdata[ST_MODE_LSB +: 4] = s.mode;
          next_s.rdata[ST_FAULT_BIT] = s.fault;
          next_s.rdata[ST_PRESENT_BIT] = s.plg_s2;
          next_s.rdata[ST_INTMEM_BIT] = int_mem_allow;
          next_s.rdata[ST_PLUG_LSB +: 7] = s.pstate;
        end
        REG_PORT_MON: next_s.rdata[NPORT-1:0] = s.port_mon;
        REG_SUP_MON: next_s.rdata[1:0] = s.sup_mon;
        REG_PLUG_ERR: next_s.rdata[2:0] = s.err;
        default: next_s.rdata = '0;
      endcase
    end

    // Signaling contact: monitored port without link, monitored supply lost, any plug error flag set
    next_s.fault = (|(s.port_mon & ~link_vec)) |
                   (|(s.sup_mon & ~s.sup_s2)) |
                   (|s.err);

    // Supply indicators
    if (s.mode == MODE_D)
    begin
      next_s.sup1 = s.sup_mon[0];
      next_s.sup2 = s.sup_mon[1];
      next_s.supc = ssi_pair_col(s.sup_mon);
    end
    else
    begin
      next_s.sup1 = s.sup_s2[0];
      next_s.sup2 = s.sup_s2[1];
      next_s.supc = ssi_pair_col(s.sup_s2);
    end

    // Mode indicator; D alternates yellow and orange
    case (s.mode)
      MODE_B: next_s.viewc = COL_GREEN;
      MODE_C: next_s.viewc = COL_ORANGE;
      MODE_D: next_s.viewc = blink.w1 ? COL_YELLOW : COL_ORANGE;
      default: next_s.viewc = COL_OFF;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s <= '0;
      s.mode <= MODE_A;
      s.pstate <= PL_START;
      s.err <= PLUG_ERR_RESET;
      s.sup_mon <= SUP_MON_RESET;
    end
    else
      s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign prdata = s.rdata;
  assign pready = 1'b1;
  assign pslverr = s.slverr;
  assign plug_store_req = (s.pstate == PL_STORE);
  assign plug_load_req = (s.pstate == PL_LOAD);
  assign int_mem_allow = (s.pstate == PL_NONE) && !s.plg_s2;
  assign plug_diag = |s.err;
  assign supply_one_indicator = s.sup1;
  assign supply_two_indicator = s.sup2;
  assign supply_indicator = s.supc;
  assign view_select_indicator = s.viewc;
  assign fault_contact = s.fault;

endmodule

// *** hw/ssi_pkg.sv ***
// Shared constants and types of the switch status indicator block
package ssi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_HZ = 10_000_000;
  localparam int BLINK_BASE_HZ = 24;
  localparam int BLINK_DIV_CYCLES = CLK_HZ / BLINK_BASE_HZ;
  localparam int HALF_1HZ_TICKS = BLINK_BASE_HZ / 2;
  localparam int HALF_3HZ_TICKS = BLINK_BASE_HZ / 6;
  localparam int HALF_4HZ_TICKS = BLINK_BASE_HZ / 8;
  localparam int MODE_TIMEOUT_S = 60;
  localparam int MODE_TIMEOUT_TICKS = MODE_TIMEOUT_S * BLINK_BASE_HZ;
  localparam int PLUG_SETTLE_CYCLES = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam logic [11:0] REG_STATUS = 12'h000;
  localparam logic [11:0] REG_PORT_MON = 12'h004;
  localparam logic [11:0] REG_SUP_MON = 12'h008;
  localparam logic [11:0] REG_PLUG_CTRL = 12'h00c;
  localparam logic [11:0] REG_PLUG_ERR = 12'h010;

  // Field positions
  localparam int ST_MODE_LSB = 0;
  localparam int ST_FAULT_BIT = 4;
  localparam int ST_PRESENT_BIT = 5;
  localparam int ST_INTMEM_BIT = 6;
  localparam int ST_PLUG_LSB = 8;
  localparam int CTRL_CHANGED_BIT = 0;
  localparam int ERR_INCOMPAT_BIT = 0;
  localparam int ERR_REMOVED_BIT = 1;
  localparam int ERR_MALF_BIT = 2;

  // Reset values
  localparam logic [1:0] SUP_MON_RESET = 2'h0;
  localparam logic [2:0] PLUG_ERR_RESET = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Indicator colours
  typedef logic [1:0] ssi_color_t;
  localparam ssi_color_t COL_OFF = 2'h0;
  localparam ssi_color_t COL_GREEN = 2'h1;
  localparam ssi_color_t COL_YELLOW = 2'h2;
  localparam ssi_color_t COL_ORANGE = 2'h3;

  // Port speed codes
  localparam logic [1:0] SPEED_10 = 2'h0;
  localparam logic [1:0] SPEED_100 = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;

  // Display modes
  typedef enum logic [3:0] {
    MODE_A = 4'h1,
    MODE_B = 4'h2,
    MODE_C = 4'h4,
    MODE_D = 4'h8
  } ssi_mode_t;

  // Configuration plug states
  typedef enum logic [6:0] {
    PL_START = 7'h01,
    PL_NONE = 7'h02,
    PL_STORE = 7'h04,
    PL_LOAD = 7'h08,
    PL_ACCEPT = 7'h10,
    PL_REFUSE = 7'h20,
    PL_FAULT = 7'h40
  } ssi_plug_t;

  // Status of one switch port, from the switch core
  typedef struct packed {
    logic link;
    logic blocking;
    logic disabled;
    logic mirror;
    logic rx_act;
    logic tx_act;
    logic optical_gig;
    logic [1:0] speed;
    logic full_duplex;
    logic autoneg;
    logic [1:0] cfg_speed;
  } ssi_port_stat_t;

  // Common blink waves
  typedef struct packed {
    logic w1;
    logic w3;
    logic w4;
  } ssi_blink_t;

endpackage

// *** hw/ssi_blink.sv ***
// Free-running blink rate generator
`timescale 1ns/1ps
module ssi_blink
  import ssi_pkg::*;
#(
  parameter int DIV = BLINK_DIV_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Base tick and blink waves
  output logic tick,
  output ssi_blink_t blink
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
    logic [3:0] c1;
    logic [3:0] c3;
    logic [3:0] c4;
    ssi_blink_t w;
  } ssi_blink_state_t;

  ssi_blink_state_t s;
  ssi_blink_state_t next_s;

  // Half-period step: returns wave and counter
  function automatic logic [4:0] ssi_step(input logic [3:0] c, input logic w,
                                          input logic [3:0] lim);
    if (c == lim)
      return {~w, 4'h0};
    else
      return {w, c + 4'h1};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // One divider for every wave keeps all phases aligned
  always_comb
  begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt == CW'(DIV - 1))
    begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end
    else
      next_s.cnt = s.cnt + 1'b1;
    if (s.tick)
    begin
      {next_s.w.w1, next_s.c1} = ssi_step(s.c1, s.w.w1, 4'(HALF_1HZ_TICKS - 1));
      {next_s.w.w3, next_s.c3} = ssi_step(s.c3, s.w.w3, 4'(HALF_3HZ_TICKS - 1));
      {next_s.w.w4, next_s.c4} = ssi_step(s.c4, s.w.w4, 4'(HALF_4HZ_TICKS - 1));
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      s <= '0;
    else
      s <= next_s;
  end

  assign tick = s.tick;
  assign blink = s.w;

endmodule

// *** hw/ssi_port_led.sv ***
// Colour of one port indicator for the active display mode
`timescale 1ns/1ps
module ssi_port_led
  import ssi_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Display context
  input wire ssi_mode_t mode,
  input wire ssi_blink_t blink,
  input wire logic monitored,
  // Port state
  input wire ssi_port_stat_t stat,
  // Indicator
  output ssi_color_t color
);

  typedef struct packed {
    ssi_color_t color;
  } ssi_led_state_t;

  ssi_led_state_t s;
  ssi_led_state_t next_s;

  // Speed code to colour
  function automatic ssi_color_t ssi_speed_col(input logic [1:0] sp);
    case (sp)
      SPEED_100: return COL_GREEN;
      SPEED_1000: return COL_ORANGE;
      default: return COL_OFF;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Mode A priorities: link, activity, mirror, disabled, blocking
  always_comb
  begin
    next_s = s;
    case (mode)
      MODE_A:
      begin
        if (!stat.link)
          next_s.color = COL_OFF;
        else if (stat.rx_act || (stat.optical_gig && stat.tx_act))
          next_s.color = COL_YELLOW;
        else if (stat.mirror)
          next_s.color = blink.w4 ? COL_GREEN : COL_OFF;
        else if (stat.disabled)
          next_s.color = blink.w3 ? COL_GREEN : COL_OFF;
        else if (stat.blocking)
          next_s.color = blink.w1 ? COL_GREEN : COL_OFF;
        else
          next_s.color = COL_GREEN;
      end
      MODE_B:
      begin
        if (stat.link)
          next_s.color = ssi_speed_col(stat.speed);
        else if (stat.autoneg)
          next_s.color = COL_OFF;
        else
          next_s.color = ssi_speed_col(stat.cfg_speed);
      end
      MODE_C:
        next_s.color = stat.full_duplex ? COL_GREEN : COL_OFF;
      MODE_D:
        next_s.color = monitored ? COL_GREEN : COL_OFF;
      default:
        next_s.color = COL_OFF;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      s <= '0;
    else
      s <= next_s;
  end

  assign color = s.color;

endmodule

// *** test/ssi_props.sv ***
// Port checker of the switch status indicator top
`timescale 1ns/1ps
module ssi_props
  import ssi_pkg::*;
#(
  parameter int NPORT = 8,
  parameter int BLINK_DIV = BLINK_DIV_CYCLES,
  parameter logic [15:0] TIMEOUT_TICKS = 16'(MODE_TIMEOUT_TICKS)
)
(
  // Clock and reset
  input logic clk,
  input logic rst_b,
  // Pins and port state
  input logic mode_button,
  input logic [1:0] supply_good,
  input ssi_port_stat_t [NPORT-1:0] port_stat,
  input logic plug_present,
  input logic plug_xfer_done,
  input logic plug_xfer_err,
  // Plug control
  input logic plug_store_req,
  input logic plug_load_req,
  input logic int_mem_allow,
  input logic plug_diag,
  // Indicators
  input ssi_color_t [NPORT-1:0] port_indicator,
  input logic supply_one_indicator,
  input ssi_color_t supply_indicator,
  input ssi_color_t view_select_indicator,
  input logic fault_contact
);
  localparam int IDLE_MAX = (int'(TIMEOUT_TICKS) + 2) * BLINK_DIV + 8;
  int idle;
  logic in_a;

  // Dark view indicator marks mode A
  assign in_a = (view_select_indicator == COL_OFF);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Cycles spent outside mode A with the button left alone
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      idle <= 0;
    else if (mode_button || in_a)
      idle <= 0;
    else
      idle <= idle + 1;

  function automatic ssi_color_t spd_col(input logic [1:0] s);
    return (s == SPEED_1000) ? COL_ORANGE : (s == SPEED_100) ? COL_GREEN : COL_OFF;
  endfunction

  // Five quiet cycles in mode A cover the sync delay
  sequence s_quiet_a;
    (in_a && $stable(supply_good)) [*5];
  endsequence

  ////////////////////////////////////////////////////////////
  a_plug_mem_off: assert property (plug_present [*4] |-> !int_mem_allow)
    else $error("memory open");
  a_store_alone: assert property (plug_store_req |-> !plug_load_req && !int_mem_allow)
    else $error("store overlap");
  a_store_ends: assert property (plug_store_req && plug_xfer_done |=> !plug_store_req)
    else $error("store stuck");
  a_load_ends: assert property (plug_load_req && plug_xfer_done |=> !plug_load_req)
    else $error("load stuck");
  a_xfer_err_diag: assert property ((plug_store_req || plug_load_req) && plug_xfer_err
    |-> ##[1:2] plug_diag)
    else $error("error unflagged");
  a_diag_fault: assert property ($rose(plug_diag) |-> ##[0:1] fault_contact)
    else $error("no fault");
  a_supply_one: assert property (s_quiet_a |-> supply_one_indicator == supply_good[0])
    else $error("supply one");
  a_supply_sum: assert property (s_quiet_a |-> supply_indicator == (supply_good == 2'h3 ?
    COL_GREEN : ^supply_good ? COL_ORANGE : COL_OFF))
    else $error("supply sum");
  a_port_dark: assert property ((in_a && !port_stat[0].link) [*2]
    |-> port_indicator[0] == COL_OFF)
    else $error("port lit");
  a_speed_show: assert property ((view_select_indicator == COL_GREEN && $stable(port_stat[0]))
    [*2] |-> port_indicator[0] == (port_stat[0].link ? spd_col(port_stat[0].speed) :
    port_stat[0].autoneg ? COL_OFF : spd_col(port_stat[0].cfg_speed)))
    else $error("speed colour");
  a_mode_return: assert property (idle <= IDLE_MAX)
    else $error("no return");

  c_store: cover property (plug_store_req ##1 !plug_store_req);
  c_load: cover property ($rose(plug_load_req));
  c_fault: cover property ($rose(fault_contact));
endmodule

bind ssi_top ssi_props #(.NPORT(NPORT), .BLINK_DIV(BLINK_DIV), .TIMEOUT_TICKS(TIMEOUT_TICKS))
  u_props (.clk, .rst_b, .mode_button, .supply_good, .port_stat, .plug_present, .plug_xfer_done,
  .plug_xfer_err, .plug_store_req, .plug_load_req, .int_mem_allow, .plug_diag, .port_indicator,
  .supply_one_indicator, .supply_indicator, .view_select_indicator, .fault_contact);

// *** test/ssi_plug_model.sv ***
// Behavioural model of the removable configuration plug
`timescale 1ns/1ps
module ssi_plug_model
(
  // Clock and reset
  input logic clk,
  input logic rst_b,
  // Plug kind and answer latency
  input logic fitted,
  input logic empty,
  input logic compat,
  input logic broken,
  input logic [3:0] lat,
  // Requests and plug lines
  input logic store_req,
  input logic load_req,
  output logic plug_present,
  output logic plug_blank,
  output logic plug_compat,
  output logic plug_xfer_done,
  output logic plug_xfer_err
);
  logic [3:0] cnt;
  logic junk;

  // No plug fitted: contact lines float, so show a moving pattern
  assign plug_present = fitted;
  assign plug_blank = fitted ? empty : junk;
  assign plug_compat = fitted ? compat : ~junk;

  // One answer pulse lat+1 cycles into each request
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      cnt <= 4'h0;
      junk <= 1'b0;
      plug_xfer_done <= 1'b0;
      plug_xfer_err <= 1'b0;
    end
    else
    begin
      junk <= ~junk;
      plug_xfer_done <= 1'b0;
      plug_xfer_err <= 1'b0;
      if (!(store_req || load_req) || plug_xfer_done || plug_xfer_err)
        cnt <= 4'h0;
      else if (cnt == lat)
      begin
        plug_xfer_done <= !broken;
        plug_xfer_err <= broken;
      end
      else
        cnt <= cnt + 4'h1;
    end
endmodule

// *** test/switch_status_indicator_tb.sv ***
// Self-checking bench of the switch status indicator
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t got %0h want %0h", $time, a, b); end end
module switch_status_indicator_tb
  import ssi_pkg::*;
;
  localparam int BDIV = 4;
  localparam logic [15:0] TOT = 16'h0064;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mode_button = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, supply_one_indicator, supply_two_indicator, fault_contact;
  logic [1:0] supply_good = 2'h3;
  ssi_port_stat_t [7:0] ps = '0;
  logic fitted = 1'b0, empty = 1'b0, compat = 1'b0, broken = 1'b0;
  logic [3:0] lat = 4'h1;
  logic plug_present, plug_blank, plug_compat, plug_xfer_done, plug_xfer_err;
  logic plug_store_req, plug_load_req, int_mem_allow, plug_diag;
  ssi_color_t [7:0] port_indicator;
  ssi_color_t supply_indicator, view_select_indicator;
  int n_errors = 0, n_tests = 0, cycles = 0;

  ssi_top #(.BLINK_DIV(BDIV), .TIMEOUT_TICKS(TOT)) u_dut (.clk, .rst_b, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .mode_button, .supply_good, .port_stat(ps),
    .plug_present, .plug_blank, .plug_compat, .plug_xfer_done, .plug_xfer_err, .plug_store_req,
    .plug_load_req, .int_mem_allow, .plug_diag, .port_indicator, .supply_one_indicator,
    .supply_two_indicator, .supply_indicator, .view_select_indicator, .fault_contact);
  ssi_plug_model u_plug (.clk, .rst_b, .fitted, .empty, .compat, .broken, .lat,
    .store_req(plug_store_req), .load_req(plug_load_req), .plug_present, .plug_blank,
    .plug_compat, .plug_xfer_done, .plug_xfer_err);

  // 100 ns clock and a ceiling on run length
  initial
    forever #50 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      $display("[ERR] %0t run hung", $time);
      print_verdict;
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Outputs are judged mid-cycle, well clear of the edge
  task automatic look(input int n);
    cyc(n);
    @(negedge clk);
  endtask
  task automatic apb(input logic [11:0] a, input logic w = 1'b0, input logic [31:0] d = 32'h0);
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic press;
    @(posedge clk);
    mode_button <= 1'b1;
    cyc(3);
    mode_button <= 1'b0;
    look(6);
  endtask
  // Plug set before reset, steady from it
  task automatic boot(input logic f, e, c, b, input logic [3:0] l);
    @(posedge clk);
    fitted <= f;
    empty <= e;
    compat <= c;
    broken <= b;
    lat <= l;
    rst_b <= 1'b0;
    cyc(12);
    rst_b <= 1'b1;
    look(8);
  endtask
  // Cycles between two colour changes of one port
  task automatic half(input int i, input int want);
    ssi_color_t c;
    int n;
    for (int r = 0; r < 2; r++)
    begin
      c = port_indicator[i];
      n = 0;
      while (port_indicator[i] === c && n < 400)
      begin
        @(negedge clk);
        n++;
      end
    end
    `CHK(n, want)
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    apb(REG_SUP_MON);
    `CHK(rd, {30'h0, SUP_MON_RESET})
    apb(12'h0f0);
    `CHK(er, 1'b1)
    apb(REG_STATUS);
    `CHK(rd[14:8], PL_NONE)
    `CHK(int_mem_allow, 1'b1)
  endtask
  task automatic t_mode_a;
    @(posedge clk);
    ps <= {13'h1200, 13'h1400, 13'h1800, 13'h1800, 13'h10c0, 13'h1100, 13'h1000, 13'h0000};
    look(4);
    `CHK(port_indicator[0], COL_OFF)
    `CHK(port_indicator[1], COL_GREEN)
    `CHK(port_indicator[3:2], 4'ha)
    half(4, HALF_1HZ_TICKS * BDIV);
    half(6, HALF_3HZ_TICKS * BDIV);
    half(7, HALF_4HZ_TICKS * BDIV);
    for (int k = 0; k < 6; k++)
    begin
      look(9);
      `CHK(port_indicator[5], port_indicator[4])
    end
  endtask
  task automatic t_supply;
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clk);
      supply_good <= 2'(s);
      look(6);
      `CHK({supply_two_indicator, supply_one_indicator}, 2'(s))
      `CHK(supply_indicator, s == 3 ? COL_GREEN : s == 0 ? COL_OFF : COL_ORANGE)
    end
  endtask
  task automatic t_modes;
    apb(REG_PORT_MON, 1'b1, 32'h41);
    apb(REG_SUP_MON, 1'b1, 32'h1);
    @(posedge clk);
    ps <= {13'h0000, 13'h1018, 13'h0001, 13'h0002, 13'h0004, 13'h1020, 13'h1010, 13'h1000};
    press;
    `CHK(view_select_indicator, COL_GREEN)
    `CHK(port_indicator, 16'h1734)
    press;
    `CHK(view_select_indicator, COL_ORANGE)
    `CHK(port_indicator, 16'h1000)
    press;
    `CHK(view_select_indicator inside {COL_YELLOW, COL_ORANGE}, 1'b1)
    `CHK(port_indicator, 16'h1001)
    `CHK({supply_two_indicator, supply_one_indicator, fault_contact}, 3'h2)
    for (int s = 1; s < 4; s++)
    begin
      @(posedge clk);
      supply_good <= 2'(s);
      look(6);
      `CHK(fault_contact, s == 2)
    end
    @(posedge clk);
    ps[0] <= 13'h0000;
    look(4);
    `CHK(fault_contact, 1'b1)
  endtask
  task automatic t_timeout;
    int n;
    press;
    press;
    n = 0;
    while (view_select_indicator !== COL_OFF && n < 1000)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(n >= (TOT - 2) * BDIV && n <= (TOT + 1) * BDIV, 1'b1)
  endtask
  task automatic t_plug;
    boot(1'b1, 1'b1, 1'b0, 1'b0, 4'h9);
    `CHK({plug_store_req, int_mem_allow}, 2'h2)
    look(12);
    apb(REG_PLUG_CTRL, 1'b1, 32'h1);
    look(2);
    `CHK(plug_store_req, 1'b1)
    boot(1'b1, 1'b0, 1'b1, 1'b0, 4'h9);
    `CHK({plug_load_req, plug_store_req}, 2'h2)
    look(12);
    apb(REG_STATUS);
    `CHK(rd[14:8], PL_ACCEPT)
    boot(1'b1, 1'b0, 1'b0, 1'b0, 4'h1);
    apb(REG_STATUS);
    `CHK(rd[14:8], PL_REFUSE)
    apb(REG_PLUG_ERR);
    `CHK(rd, 32'h1 << ERR_INCOMPAT_BIT)
    `CHK({plug_diag, fault_contact}, 2'h3)
    apb(REG_PLUG_ERR, 1'b1, 32'h1);
    apb(REG_PLUG_ERR);
    `CHK(rd, 32'h0)
    boot(1'b1, 1'b1, 1'b0, 1'b1, 4'h1);
    apb(REG_PLUG_ERR);
    `CHK(rd, 32'h1 << ERR_MALF_BIT)
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Plug absent from time zero
  initial
  begin
    cyc(12);
    rst_b <= 1'b1;
    look(8);
    t_regs;
    t_mode_a;
    t_supply;
    t_modes;
    t_timeout;
    t_plug;
    print_verdict;
  end
endmodule
